/* spu_consts.svh */
// Purpose: named constants for the serial port unit
// Assumes: included by bare name from the files that use its macros
// Notes: register codes, reset values, bit positions, counts
`ifndef SPU_CONSTS_SVH
`define SPU_CONSTS_SVH
`define SPU_A_PWR 4'h0
`define SPU_A_SERIAL_CONTROL 4'h1
`define SPU_A_SERIAL_DATA_BUFFER 4'h2
`define SPU_A_RLL 4'h3
`define SPU_A_RLH 4'h4
`define SPU_A_TIMER_CONTROL 4'h5
`define SPU_A_TL 4'h6
`define SPU_A_TH 4'h7
`define SPU_A_BSRC 4'h8
`define SPU_RST_ZERO 8'h00
`define SPU_RST_RLL 8'hd9
`define SPU_RST_RLH 8'h03
`define SPU_B_BAUD_DOUBLE 7
`define SPU_B_TR 6
`define SPU_B_BD 7
`define SPU_B_SM2 5
`define SPU_B_REN 4
`define SPU_B_TB8 3
`define SPU_B_RB8 2
`define SPU_B_TI 1
`define SPU_B_RI 0
`define SPU_PRE12_LAST 4'hb
`define SPU_PRE12_HALF 4'h5
`define SPU_TL_MAX 8'hff
`define SPU_BT_MAX 10'h3ff
`define SPU_OVS_CENTRE 4'h7
`define SPU_OVS_LAST 4'hf
`define SPU_M0_BITS 4'h8
`define SPU_TX_LAST_M1 4'h9
`define SPU_TX_LAST_M23 4'ha
`define SPU_RX_LAST_M1 4'h8
`define SPU_RX_LAST_M23 4'h9
`endif

/* spu_pkg.sv */
// Purpose: types shared by the serial port unit files
// Assumes: nothing is imported, names are scoped
// Notes: state codes are one-hot
package spu_pkg;
  typedef enum logic [1:0] {
    spu_mode0 = 2'h0, spu_mode1 = 2'h1, spu_mode2 = 2'h2, spu_mode3 = 2'h3
  } spu_mode_type;
  typedef enum logic [2:0] {
    spu_tx_idle = 3'h1, spu_tx_async = 3'h2, spu_tx_sync = 3'h4
  } spu_tx_state_type;
  typedef enum logic [2:0] {
    spu_rx_idle = 3'h1, spu_rx_start = 3'h2, spu_rx_data = 3'h4
  } spu_rx_state_type;
endpackage

/* spu_baud.sv */
// Purpose: baud sources: 8-bit auto-reload timer, 10-bit reload generator
// Assumes: single clock, asynchronous active-low reset
// Notes: tick16 is the 16x oversample pulse for modes 1 to 3
`timescale 1ns/100ps
`include "spu_consts.svh"
module spu_baud #(
  parameter logic [3:0] PRE_LAST = `SPU_PRE12_LAST,
  parameter logic [3:0] PRE_HALF = `SPU_PRE12_HALF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] mode,
  input wire logic baud_double,
  input wire logic src_bit,
  input wire logic run,
  input wire logic [7:0] th,
  input wire logic [9:0] baud_reload_value,
  input wire logic tl_wr,
  input wire logic [7:0] tl_wdata,
  output logic [7:0] tl_val,
  output logic step12,
  output logic half12,
  output logic tick16
);
  logic [3:0] pre_reg;
  logic [7:0] tl_reg;
  logic [9:0] bt_reg;
  logic div2_reg;
  logic half_reg;
  logic step_run;
  logic tl_ovf;
  logic bt_ovf;
  logic src;

  // prescaler taps and overflow detection
  assign step12 = (pre_reg == PRE_LAST);
  assign half12 = (pre_reg == PRE_HALF);
  assign step_run = step12 & run;
  assign tl_ovf = step_run & (tl_reg == `SPU_TL_MAX);
  assign bt_ovf = div2_reg & (bt_reg == `SPU_BT_MAX);
  assign tl_val = tl_reg;
  // source pick by mode and bit
  assign src = (mode == spu_pkg::spu_mode2) ? div2_reg :
               mode[0] ? (src_bit ? bt_ovf : tl_ovf) : 1'b0;
  assign tick16 = src & (baud_double | half_reg);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) pre_reg <= 4'h0;
    else pre_reg <= step12 ? 4'h0 : pre_reg + 4'h1;
  end

  // eight-bit auto-reload timer; host write wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) tl_reg <= `SPU_RST_ZERO;
    else if (tl_wr) tl_reg <= tl_wdata;
    else if (step_run) tl_reg <= tl_ovf ? th : tl_reg + 8'h01;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div2_reg <= 1'b0;
      bt_reg <= 10'h000;
    end else begin
      div2_reg <= ~div2_reg;
      if (div2_reg) bt_reg <= bt_ovf ? baud_reload_value : bt_reg + 10'h001;
    end
  end

  // halver gives 32 source pulses per bit, or 16 when doubled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) half_reg <= 1'b0;
    else if (src) half_reg <= ~half_reg;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  tl_reload_a: assert property (tl_ovf && !tl_wr |=> tl_reg == $past(th))
    else $error("timer low byte not reloaded from high byte");
  tl_hold_a: assert property (!run && !tl_wr |=> $stable(tl_reg))
    else $error("timer moved while stopped");
  tl_step_a: assert property ($changed(tl_reg) && !$past(tl_wr) |-> $past(step_run))
    else $error("timer moved off the twelve-cycle step");
  bt_reload_a: assert property (bt_ovf |=> bt_reg == $past(baud_reload_value))
    else $error("generator not reloaded");
endmodule

/* spu_top.sv */
// Purpose: serial port unit with host byte registers and four modes
// Assumes: 50 MHz clk, rst_n asynchronous active low, rx_pin asynchronous
// Notes: host_read_data is registered, valid the cycle after host_rd
// Notes on behaviour
// - timer is eight-bit auto-reload only
// - timer low byte steps every twelve clocks
// - low byte overflow reloads from high byte
// - timer runs only while run bit set
// - source bit picks timer or generator
// - reset clears all but reload pair
// - mode 0 shifts eight bits, clk/12
// - mode 1 ten-bit frame, LSB first
// - mode 1 stop bit goes to ninth flag
// - modes 2,3 eleven bits, ninth from flag
// - modes 2,3 ninth bit kept, stop ignored
// - mode 2 runs clk/64, doubled clk/32
// - data buffer write starts transmission
// - mode 0 receive when done clear, enabled
// - modes 1-3 receive start bit if enabled
// - multiprocessor, modes 2,3: done only when ninth bit one
// - modes 1,3 doubled by double bit
// - generator rate from ten-bit reload
// - timer rate from reload byte
// - four-bit register select codes
// - write latches byte on clock edge
// - read drives addressed register out
// - done flags sticky until software clears
// - interrupt high while either done flag
// - mode bits decode to modes 0-3
// - generator steps every two clocks
`timescale 1ns/100ps
`include "spu_consts.svh"
module spu_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] host_addr,
  input wire logic [7:0] host_write_data,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [7:0] host_read_data,
  output logic int_out,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic shift_data_pin
);
  logic [7:2] power_baud_control_reg;
  logic [7:0] serial_control_reg;
  logic [7:0] rbuf_reg;
  logic [7:0] rll_reg;
  logic [7:0] rlh_reg;
  logic [7:0] timer_control_reg;
  logic [7:0] th_reg;
  logic bsrc_reg;
  logic [7:0] rdata_reg;
  logic [7:0] tl_val;
  logic step12;
  logic half12;
  logic tick16;
  logic rx_s1_reg;
  logic rx_s2_reg;
  logic rx_prev_reg;
  spu_pkg::spu_tx_state_type tx_state_reg;
  spu_pkg::spu_tx_state_type tx_state_next;
  spu_pkg::spu_rx_state_type rx_state_reg;
  spu_pkg::spu_rx_state_type rx_state_next;
  logic [10:0] tsh_reg;
  logic [3:0] tbit_reg;
  logic [3:0] tovs_reg;
  logic sclk_reg;
  logic m0_rx_reg;
  logic [9:0] rsh_reg;
  logic [3:0] rbit_reg;
  logic [3:0] rovs_reg;
  logic tx_pin_reg;
  logic sdo_reg;

  // host register decode
  function automatic logic hit(input logic [3:0] code, input logic [3:0] a, input logic s);
    hit = s & (a == code);
  endfunction

  // read selection; unused codes read zero
  function automatic logic [7:0] rd_mux(input logic [3:0] a, input logic [7:0] tl);
    case (a)
      `SPU_A_PWR: rd_mux = {power_baud_control_reg, 2'b00};
      `SPU_A_SERIAL_CONTROL: rd_mux = serial_control_reg;
      `SPU_A_SERIAL_DATA_BUFFER: rd_mux = rbuf_reg;
      `SPU_A_RLL: rd_mux = rll_reg;
      `SPU_A_RLH: rd_mux = rlh_reg;
      `SPU_A_TIMER_CONTROL: rd_mux = timer_control_reg;
      `SPU_A_TL: rd_mux = tl;
      `SPU_A_TH: rd_mux = th_reg;
      `SPU_A_BSRC: rd_mux = {bsrc_reg, 7'h00};
      default: rd_mux = 8'h00;
    endcase
  endfunction

  logic wr_power_baud_control;
  logic wr_serial_control;
  logic wr_serial_data_buffer;
  logic wr_tl;
  assign wr_power_baud_control = hit(`SPU_A_PWR, host_addr, host_wr);
  assign wr_serial_control = hit(`SPU_A_SERIAL_CONTROL, host_addr, host_wr);
  assign wr_serial_data_buffer = hit(`SPU_A_SERIAL_DATA_BUFFER, host_addr, host_wr);
  assign wr_tl = hit(`SPU_A_TL, host_addr, host_wr);

  spu_pkg::spu_mode_type mode;
  logic baud_double;
  logic sm2;
  logic ren;
  logic ti;
  logic ri;
  logic mode0;
  assign mode = spu_pkg::spu_mode_type'(serial_control_reg[7:6]);
  assign baud_double = power_baud_control_reg[`SPU_B_BAUD_DOUBLE];
  assign sm2 = serial_control_reg[`SPU_B_SM2];
  assign ren = serial_control_reg[`SPU_B_REN];
  assign ti = serial_control_reg[`SPU_B_TI];
  assign ri = serial_control_reg[`SPU_B_RI];
  assign mode0 = (mode == spu_pkg::spu_mode0);

  // baud sources; ten-bit reload from low byte and two bits
  spu_baud u_baud (
    .clk(clk),
    .rst_n(rst_n),
    .mode(serial_control_reg[7:6]),
    .baud_double(baud_double),
    .src_bit(bsrc_reg),
    .run(timer_control_reg[`SPU_B_TR]),
    .th(th_reg),
    .baud_reload_value({rlh_reg[1:0], rll_reg}),
    .tl_wr(wr_tl),
    .tl_wdata(host_write_data),
    .tl_val(tl_val),
    .step12(step12),
    .half12(half12),
    .tick16(tick16)
  );

  // rx pin synchroniser; the second stage and its delayed copy feed logic, the first does not
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_s1_reg <= rx_pin;
      rx_s2_reg <= rx_s1_reg;
      rx_prev_reg <= rx_s2_reg;
    end
  end

  // transmit / mode 0 engine decisions
  logic m0_rx_go;
  logic tx_last_hit;
  logic tx_done;
  logic m0_done;
  logic [3:0] tx_last;
  logic ninth_out;
  assign m0_rx_go = mode0 & ~ri & ren & ~wr_serial_data_buffer;
  assign tx_last = (mode == spu_pkg::spu_mode1) ? `SPU_TX_LAST_M1 : `SPU_TX_LAST_M23;
  assign tx_last_hit = tick16 & (tovs_reg == `SPU_OVS_LAST) & (tbit_reg == tx_last);
  assign m0_done = step12 & (tbit_reg == `SPU_M0_BITS);
  // mode 1 stop bit sits where the ninth bit would
  assign ninth_out = (mode == spu_pkg::spu_mode1) ? 1'b1 : serial_control_reg[`SPU_B_TB8];
  assign tx_done = (tx_state_reg == spu_pkg::spu_tx_async) & tx_last_hit |
                   (tx_state_reg == spu_pkg::spu_tx_sync) & m0_done & ~m0_rx_reg;

  // a buffer write restarts the engine even mid-frame
  always_comb begin
    tx_state_next = tx_state_reg;
    case (tx_state_reg)
      spu_pkg::spu_tx_idle: begin
        if (wr_serial_data_buffer) tx_state_next = mode0 ? spu_pkg::spu_tx_sync : spu_pkg::spu_tx_async;
        else if (m0_rx_go) tx_state_next = spu_pkg::spu_tx_sync;
      end
      spu_pkg::spu_tx_async: begin
        if (wr_serial_data_buffer) tx_state_next = mode0 ? spu_pkg::spu_tx_sync : spu_pkg::spu_tx_async;
        else if (tx_last_hit) tx_state_next = spu_pkg::spu_tx_idle;
      end
      spu_pkg::spu_tx_sync: begin
        if (wr_serial_data_buffer) tx_state_next = mode0 ? spu_pkg::spu_tx_sync : spu_pkg::spu_tx_async;
        else if (m0_done) tx_state_next = spu_pkg::spu_tx_idle;
      end
      default: tx_state_next = spu_pkg::spu_tx_idle;
    endcase
  end

  // async frame: start, data, ninth or stop, stop
  // mode 0: clock low at step, rise at half, LSB first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state_reg <= spu_pkg::spu_tx_idle;
      tsh_reg <= 11'h7ff;
      tbit_reg <= 4'h0;
      tovs_reg <= 4'h0;
      sclk_reg <= 1'b1;
      m0_rx_reg <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      if (wr_serial_data_buffer) begin
        tsh_reg <= {1'b1, ninth_out, host_write_data, 1'b0};
        tbit_reg <= 4'h0;
        tovs_reg <= 4'h0;
        sclk_reg <= 1'b1;
        m0_rx_reg <= 1'b0;
        if (mode0) tsh_reg <= {3'h7, host_write_data};
      end else if (tx_state_reg == spu_pkg::spu_tx_idle) begin
        tbit_reg <= 4'h0;
        sclk_reg <= 1'b1;
        m0_rx_reg <= m0_rx_go;
      end else if (tx_state_reg == spu_pkg::spu_tx_async) begin
        if (tick16) tovs_reg <= tovs_reg + 4'h1;
        if (tick16 && tovs_reg == `SPU_OVS_LAST) begin
          tsh_reg <= {1'b1, tsh_reg[10:1]};
          tbit_reg <= tbit_reg + 4'h1;
        end
      end else if (step12) begin
        sclk_reg <= m0_done;
        if (tbit_reg != 4'h0 && !m0_rx_reg) tsh_reg <= {1'b1, tsh_reg[10:1]};
      end else if (half12 && !sclk_reg) begin
        sclk_reg <= 1'b1;
        tbit_reg <= tbit_reg + 4'h1;
        if (m0_rx_reg) tsh_reg <= {3'h7, rx_s2_reg, tsh_reg[7:1]};
      end
    end
  end

  // pin drivers; idle line is high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pin_reg <= 1'b1;
      sdo_reg <= 1'b1;
    end else begin
      tx_pin_reg <= (tx_state_reg == spu_pkg::spu_tx_sync) ? sclk_reg :
                    (tx_state_reg == spu_pkg::spu_tx_async) ? tsh_reg[0] : 1'b1;
      sdo_reg <= (tx_state_reg == spu_pkg::spu_tx_sync) & ~m0_rx_reg ? tsh_reg[0] : 1'b1;
    end
  end
  assign tx_pin = tx_pin_reg;
  assign shift_data_pin = sdo_reg;

  // receive decisions on the oversample grid
  logic rx_fall;
  logic rx_centre;
  logic rx_bit_end;
  logic [3:0] rx_last;
  logic rx_finish;
  logic [7:0] rx_data;
  logic rx_ninth;
  logic rx_accept;
  assign rx_fall = rx_prev_reg & ~rx_s2_reg;
  assign rx_centre = tick16 & (rovs_reg == `SPU_OVS_CENTRE);
  assign rx_bit_end = tick16 & (rovs_reg == `SPU_OVS_LAST);
  assign rx_last = (mode == spu_pkg::spu_mode1) ? `SPU_RX_LAST_M1 : `SPU_RX_LAST_M23;
  assign rx_finish = (rx_state_reg == spu_pkg::spu_rx_data) & rx_bit_end & (rbit_reg == rx_last);
  // mode 1 stop is the ninth flag; modes 2,3 take bit nine
  assign rx_data = (mode == spu_pkg::spu_mode1) ? rsh_reg[9:2] : rsh_reg[8:1];
  assign rx_ninth = (mode == spu_pkg::spu_mode1) ? rx_s2_reg : rsh_reg[9];
  // address filter in modes 2 and 3
  assign rx_accept = rx_finish & ~(mode[1] & sm2 & ~rx_ninth);

  // start only while enabled and not in mode 0
  always_comb begin
    rx_state_next = rx_state_reg;
    case (rx_state_reg)
      spu_pkg::spu_rx_idle:
        if (rx_fall && ren && !mode0) rx_state_next = spu_pkg::spu_rx_start;
      spu_pkg::spu_rx_start:
        if (rx_centre) rx_state_next = rx_s2_reg ? spu_pkg::spu_rx_idle : spu_pkg::spu_rx_data;
      spu_pkg::spu_rx_data:
        if (rx_finish) rx_state_next = spu_pkg::spu_rx_idle;
      default: rx_state_next = spu_pkg::spu_rx_idle;
    endcase
  end

  // count restarts at the start-bit centre so later samples land mid-bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state_reg <= spu_pkg::spu_rx_idle;
      rsh_reg <= 10'h000;
      rbit_reg <= 4'h0;
      rovs_reg <= 4'h0;
    end else begin
      rx_state_reg <= rx_state_next;
      if (rx_state_reg == spu_pkg::spu_rx_idle) begin
        rovs_reg <= 4'h0;
        rbit_reg <= 4'h0;
      end else if (rx_centre && rx_state_reg == spu_pkg::spu_rx_start) begin
        rovs_reg <= 4'h0;
      end else if (tick16) begin
        rovs_reg <= rovs_reg + 4'h1;
        if (rx_bit_end && !rx_finish) begin
          rsh_reg <= {rx_s2_reg, rsh_reg[9:1]};
          rbit_reg <= rbit_reg + 4'h1;
        end
      end
    end
  end

  // hardware set wins over a host write that clears in the same cycle
  logic m0_rx_done;
  logic ri_set;
  logic [7:0] serial_control_wr;
  logic [7:0] serial_control_next;
  assign m0_rx_done = (tx_state_reg == spu_pkg::spu_tx_sync) & m0_done & m0_rx_reg & ~wr_serial_data_buffer;
  assign ri_set = rx_accept | m0_rx_done;
  assign serial_control_wr = wr_serial_control ? host_write_data : serial_control_reg;
  assign serial_control_next = {serial_control_wr[7:3], rx_accept ? rx_ninth : serial_control_wr[`SPU_B_RB8],
                      serial_control_wr[`SPU_B_TI] | tx_done, serial_control_wr[`SPU_B_RI] | ri_set};

  // host registers; reload pair resets to its own value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_baud_control_reg <= 6'h00;
      serial_control_reg <= `SPU_RST_ZERO;
      rbuf_reg <= `SPU_RST_ZERO;
      rll_reg <= `SPU_RST_RLL;
      rlh_reg <= `SPU_RST_RLH;
      timer_control_reg <= `SPU_RST_ZERO;
      th_reg <= `SPU_RST_ZERO;
      bsrc_reg <= 1'b0;
    end else begin
      serial_control_reg <= serial_control_next;
      if (wr_power_baud_control) power_baud_control_reg <= host_write_data[7:2];
      if (hit(`SPU_A_RLL, host_addr, host_wr)) rll_reg <= host_write_data;
      if (hit(`SPU_A_RLH, host_addr, host_wr)) rlh_reg <= host_write_data;
      if (hit(`SPU_A_TIMER_CONTROL, host_addr, host_wr)) timer_control_reg <= host_write_data;
      if (hit(`SPU_A_TH, host_addr, host_wr)) th_reg <= host_write_data;
      // only the source bit is stored
      if (hit(`SPU_A_BSRC, host_addr, host_wr)) bsrc_reg <= host_write_data[`SPU_B_BD];
      // overrun simply overwrites the unread byte
      if (rx_accept) rbuf_reg <= rx_data;
      else if (m0_rx_done) rbuf_reg <= tsh_reg[7:0];
    end
  end

  // read data captured on the strobe, held otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rdata_reg <= 8'h00;
    else if (host_rd) rdata_reg <= rd_mux(host_addr, tl_val);
  end
  assign host_read_data = rdata_reg;

  assign int_out = ti | ri;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  tx_start_a: assert property (wr_serial_data_buffer |=> tx_state_reg != spu_pkg::spu_tx_idle)
    else $error("buffer write did not start transmission");
  start_bit_a: assert property (wr_serial_data_buffer && !mode0 ##1 !wr_serial_data_buffer |=> ##1 !tx_pin)
    else $error("async frame did not open with a low start bit");
  ti_set_a: assert property (tx_done |=> ti && int_out)
    else $error("transmit done flag not set");
  ri_hold_a: assert property (ri && !wr_serial_control |=> ri)
    else $error("receive done flag dropped without a host write");
  rx_gate_a: assert property (rx_state_reg == spu_pkg::spu_rx_idle && (!ren || mode0)
    |=> rx_state_reg == spu_pkg::spu_rx_idle)
    else $error("receive started while disabled");
  mp_filter_a: assert property (rx_finish && mode[1] && sm2 && !rx_ninth && !ri && !wr_serial_control
    |=> !ri)
    else $error("data byte raised done flag under address filter");
  rb8_stop_a: assert property (rx_finish && mode == spu_pkg::spu_mode1 && !sm2
    |=> serial_control_reg[`SPU_B_RB8] == $past(rx_s2_reg))
    else $error("mode 1 stop bit not stored in ninth flag");
  int_level_a: assert property (!ti && !ri |-> !int_out)
    else $error("interrupt high with both flags clear");
endmodule

/* spu_peer.sv */
// Purpose: serial peer on the far side of the serial port unit
// Assumes: bit lengths are given in system clocks by the caller
// Notes: rx_line idles high like a pulled-up line between frames
`timescale 1ns/100ps
module spu_peer (
  input wire logic clk,
  input wire logic tx_line,
  input wire logic shift_line,
  output logic rx_line
);
  // idle level before the first frame
  initial begin
    rx_line = 1'b1;
  end

  task automatic send(input int n, input int bitc, input logic [10:0] f);
    @(posedge clk);
    for (int i = 0; i < n; i++) begin
      #2 rx_line = f[i];
      repeat (bitc) @(posedge clk);
    end
    #2 rx_line = 1'b1;
  endtask

  // sample each bit in its centre, start bit lands in f[0]
  task automatic capture(input int n, input int bitc, output logic [10:0] f);
    f = '0;
    @(negedge tx_line);
    repeat (bitc / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      f[i] = tx_line;
      repeat (bitc) @(posedge clk);
    end
  endtask

  // shift data taken at rising shift clock
  task automatic shift_in(output logic [7:0] d, output int per);
    realtime t;
    t = 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge tx_line);
      d[i] = shift_line;
      if (i == 0) begin
        t = $realtime;
      end
      if (i == 1) begin
        per = int'($realtime - t);
      end
    end
  endtask

  // new bit presented after each falling shift clock
  task automatic shift_out(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge tx_line);
      #2 rx_line = d[i];
    end
    @(posedge tx_line);
    #2 rx_line = 1'b1;
  endtask
endmodule

/* tb.sv */
// Purpose: self-checking bench for the serial port unit
// Assumes: 50 MHz clock, host strobes driven 2 ns after the rising edge
// Notes: expected frames are built by hand, start bit in bit 0
`timescale 1ns/100ps
`include "spu_consts.svh"
module tb;
  logic clk, rst_n, host_wr, host_rd, int_out, tx_pin, shift_data_pin, rx_pin;
  logic [3:0] host_addr;
  logic [7:0] host_write_data, host_read_data, rd_val;
  logic [10:0] frm;
  int err_count, check_count, per;
  logic [7:0] rst_tab [10] = '{8'h00, 8'h00, 8'h00, 8'hd9, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  spu_top uut (.clk(clk), .rst_n(rst_n), .host_addr(host_addr), .host_write_data(host_write_data),
    .host_wr(host_wr), .host_rd(host_rd), .host_read_data(host_read_data), .int_out(int_out),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .shift_data_pin(shift_data_pin));
  spu_peer peer (.clk(clk), .tx_line(tx_pin), .shift_line(shift_data_pin), .rx_line(rx_pin));

  // 20 ns clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic print_verdict();
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [10:0] exp, input logic [10:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one strobe cycle per access, a free cycle between accesses
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) #2;
    host_addr = a;
    host_write_data = d;
    host_wr = 1'b1;
    @(posedge clk) #2 host_wr = 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk) #2;
    host_addr = a;
    host_rd = 1'b1;
    @(posedge clk) #2 host_rd = 1'b0;
    d = host_read_data;
  endtask

  task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] e);
    rd(a, rd_val);
    check(nm, {3'h0, e}, {3'h0, rd_val});
  endtask

  task automatic tx_frame(input int n, input int bitc, input logic [7:0] d, input logic [10:0] e);
    fork
      peer.capture(n, bitc, frm);
      wr(`SPU_A_SERIAL_DATA_BUFFER, d);
    join
    check("frame", e, frm);
  endtask

  // hang guard, longer than the whole sequence
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    print_verdict();
  end

  // main sequence
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 4'h0;
    host_write_data = 8'h00;
    err_count = 0;
    check_count = 0;
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    #2 rst_n = 1'b1;
    for (int i = 0; i < 10; i++) begin
      rchk("reset value", i[3:0], rst_tab[i]);
    end
    wr(`SPU_A_PWR, 8'hff);
    rchk("power control", `SPU_A_PWR, 8'hfc);
    wr(`SPU_A_BSRC, 8'hff);
    rchk("baud source", `SPU_A_BSRC, 8'h80);
    wr(4'h9, 8'hff);
    rchk("unmapped", 4'h9, 8'h00);
    // timer stopped, then run across an overflow
    wr(`SPU_A_TL, 8'h55);
    repeat (40) @(posedge clk);
    rchk("timer stopped", `SPU_A_TL, 8'h55);
    wr(`SPU_A_TH, 8'h80);
    wr(`SPU_A_TL, 8'hff);
    wr(`SPU_A_TIMER_CONTROL, 8'h40);
    repeat (28) @(posedge clk);
    rd(`SPU_A_TL, rd_val);
    check("timer reload", 11'h1, {10'h0, rd_val inside {8'h81, 8'h82}});
    // mode 1 on the generator, reload 0x3ff gives 64 clocks a bit
    wr(`SPU_A_PWR, 8'h00);
    wr(`SPU_A_RLL, 8'hff);
    wr(`SPU_A_SERIAL_CONTROL, 8'h40);
    // generator counts up from zero after reset; its first reload falls during the disabled-receive frame
    repeat (1500) @(posedge clk);
    peer.send(10, 64, {1'b0, 1'b1, 8'h77, 1'b0});
    repeat (8) @(posedge clk);
    rchk("rx disabled", `SPU_A_SERIAL_CONTROL, 8'h40);
    wr(`SPU_A_SERIAL_CONTROL, 8'h50);
    tx_frame(10, 64, 8'ha5, {1'b0, 1'b1, 8'ha5, 1'b0});
    rchk("tx done", `SPU_A_SERIAL_CONTROL, 8'h52);
    check("irq set", 11'h1, {10'h0, int_out});
    wr(`SPU_A_SERIAL_CONTROL, 8'h50);
    check("irq clear", 11'h0, {10'h0, int_out});
    peer.send(10, 64, {1'b0, 1'b1, 8'h3c, 1'b0});
    repeat (8) @(posedge clk);
    rchk("rx flags", `SPU_A_SERIAL_CONTROL, 8'h55);
    rchk("rx data", `SPU_A_SERIAL_DATA_BUFFER, 8'h3c);
    // mode 3 on the timer, doubled: 192 clocks a bit
    wr(`SPU_A_PWR, 8'h80);
    wr(`SPU_A_BSRC, 8'h00);
    wr(`SPU_A_TH, 8'hff);
    wr(`SPU_A_TL, 8'hff);
    wr(`SPU_A_SERIAL_CONTROL, 8'hf8);
    tx_frame(11, 192, 8'h5a, {1'b1, 1'b1, 8'h5a, 1'b0});
    wr(`SPU_A_SERIAL_CONTROL, 8'hf8);
    peer.send(11, 192, {1'b1, 1'b0, 8'h11, 1'b0});
    repeat (8) @(posedge clk);
    rd(`SPU_A_SERIAL_CONTROL, rd_val);
    check("filtered flag", 11'h0, {10'h0, rd_val[0]});
    rchk("filtered data", `SPU_A_SERIAL_DATA_BUFFER, 8'h3c);
    peer.send(11, 192, {1'b0, 1'b1, 8'h96, 1'b0});
    repeat (8) @(posedge clk);
    rchk("address flags", `SPU_A_SERIAL_CONTROL, 8'hfd);
    rchk("address data", `SPU_A_SERIAL_DATA_BUFFER, 8'h96);
    // mode 2 at both fixed rates
    for (int s = 0; s < 2; s++) begin
      wr(`SPU_A_PWR, {s[0], 7'h00});
      wr(`SPU_A_SERIAL_CONTROL, 8'h88);
      tx_frame(11, 64 >> s, 8'hc3, {1'b1, 1'b1, 8'hc3, 1'b0});
    end
    // mode 0 shift out, then shift in
    wr(`SPU_A_SERIAL_CONTROL, 8'h00);
    fork
      peer.shift_in(rd_val, per);
      wr(`SPU_A_SERIAL_DATA_BUFFER, 8'h6b);
    join
    check("shift data", 11'h06b, {3'h0, rd_val});
    check("shift period", 11'd240, per[10:0]);
    repeat (20) @(posedge clk);
    rchk("shift done", `SPU_A_SERIAL_CONTROL, 8'h02);
    fork
      peer.shift_out(8'hd4);
      wr(`SPU_A_SERIAL_CONTROL, 8'h10);
    join
    repeat (20) @(posedge clk);
    rchk("shift rx flags", `SPU_A_SERIAL_CONTROL, 8'h11);
    rchk("shift rx data", `SPU_A_SERIAL_DATA_BUFFER, 8'hd4);
    print_verdict();
  end
endmodule
